// ### spi_dma_pkg.sv
package spi_dma_pkg;
    // ------------------------------
    // Register byte offsets
    // ------------------------------
    localparam logic [7:0] A_CTL = 8'h00;
    localparam logic [7:0] A_BAUD = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_TXD = 8'h0C;
    localparam logic [7:0] A_RXD = 8'h10;
    localparam logic [7:0] A_DCTL = 8'h14;
    localparam logic [7:0] A_IDX = 8'h18;
    localparam logic [7:0] A_MOD = 8'h1C;
    localparam logic [7:0] A_CNT = 8'h20;
    localparam logic [7:0] A_CP = 8'h24;
    localparam logic [7:0] A_IMSK = 8'h28;
    localparam logic [7:0] A_LMSK = 8'h2C;
    // ------------------------------
    // Field positions
    // ------------------------------
    localparam int C_EN = 0;
    localparam int C_MS = 1;
    localparam int C_POL = 2;
    localparam int C_PHA = 3;
    localparam int C_TIM = 4;
    localparam int C_ZF = 6;
    localparam int C_OW = 7;
    localparam int D_EN = 0;
    localparam int D_RX = 1;
    localparam int D_CH = 2;
    localparam int D_IE = 3;
    localparam int D_EE = 4;
    localparam int S_RXS = 0;
    localparam int S_TXS = 1;
    localparam int S_OVF = 2;
    localparam int S_UNF = 3;
    localparam int S_FIN = 4;
    localparam int S_DACT = 5;
    localparam int S_IRQ = 6;
    localparam int HI_MSK_BIT = 12;
    localparam int LO_MSK_BIT = 19;
    // ------------------------------
    // Modes, timing, resets
    // ------------------------------
    localparam logic [1:0] TIM_RX = 2'h0;
    localparam logic [1:0] TIM_TX = 2'h1;
    localparam logic [2:0] RXS_LAT = 3'h4;
    localparam logic [15:0] BAUD_RST = 16'h0004;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    typedef enum logic [1:0] {
        SER_IDLE = 2'h0, SER_LEAD = 2'h1, SER_SHIFT = 2'h3, SER_TAIL = 2'h2
    } ser_state_type;
    typedef enum logic [1:0] {
        DMA_IDLE = 2'h0, DMA_RUN = 2'h1, DMA_DESC = 2'h3, DMA_END = 2'h2
    } dma_state_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_type;
endpackage : spi_dma_pkg

// ### spi_dma_port.sv
// Overview of operation
// - Selected slave shifts; DMA serves one direction
// - DMA runs until count steps 1 to 0
// - Rx DMA full, no overwrite: drop word
// - Rx DMA: send zeros or transmit register
// - Rx DMA full, overwrite set: replace word
// - Tx DMA empty: zeros or repeat last
// - Tx DMA: overflow never interrupts
// - Core polls status opposite DMA direction
// - First transfer in registers; no insertion
// - Chain starts only when fully enabled
// - Opposite direction: no interrupt, no FIFO
// - Master phase0: trigger, select, half period
// - Slave phase0: starts on select fall
// - Phase1: starts first edge; end rules
// - Receive-full four clocks after sampling
// - Finished flag timing per role
// - Core interrupt on tx room/rx word
// - Rx interrupt one clock after flag
// - DMA done, chain done, error interrupts
// - Causes latch one irq; mask bits 12/19
// - Receive data read clears receive-full
// - Receive-triggered read starts transfer
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
module spi_dma_port
    import spi_dma_pkg::*;
#(
    parameter int W = 32,
    parameter bit PRIMARY = 1'b1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial pins
    input wire logic serial_clock_i,
    output logic serial_clock_o,
    output logic serial_clock_oe,
    input wire logic select_input,
    output logic select_out_n,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    // DMA memory port
    output mem_req_type dma_req,
    input wire logic dma_ready,
    input wire logic [31:0] dma_rdata,
    // Interrupts
    output logic high_priority_serial_irq,
    output logic low_priority_serial_irq
);
    // ------------------------------
    // Registers
    // ------------------------------
    logic [7:0] ctl_ff;        // serial_control_reg
    logic [15:0] baud_ff;      // baud_divisor
    logic [4:0] dctl_ff;       // dma_control_reg
    logic [31:0] txd_ff;       // transmit_data_reg
    logic [31:0] rxd_ff;       // receive_data_reg
    logic [31:0] idx_ff;       // dma_index
    logic [31:0] mod_ff;       // dma_modifier
    logic [15:0] cnt_ff;       // dma_word_count
    logic [31:0] cp_ff;        // chain_pointer
    logic hmsk_ff;             // core_irq_mask_reg bit
    logic lmsk_ff;             // low_irq_latch_mask_reg bit
    logic rxs_ff, txs_ff, ovf_ff, unf_ff, fin_ff, irq_ff;
    logic [W-1:0] last_tx_ff;  // Repeat word when starved
    logic [31:0] dbuf_ff;      // One-word DMA holding buffer
    logic dfull_ff;
    // ------------------------------
    // Decode of fields
    // ------------------------------
    wire en = ctl_ff[C_EN];
    wire master = ctl_ff[C_MS];
    wire cpol = ctl_ff[C_POL];
    wire cpha = ctl_ff[C_PHA];
    wire [1:0] initiation_mode = ctl_ff[C_TIM+1:C_TIM];
    wire zfill = ctl_ff[C_ZF];
    wire owr = ctl_ff[C_OW];
    wire d_en = dctl_ff[D_EN];
    wire d_rx = dctl_ff[D_RX];
    dma_state_type dst_ff;
    wire d_act = (dst_ff != DMA_IDLE);
    wire rx_dma = d_act & d_rx;
    wire tx_dma = d_act & ~d_rx;
    // ------------------------------
    // AHB address phase capture
    // ------------------------------
    logic wr_ff;
    logic [7:0] wa_ff;
    wire take = hsel & hready & htrans[1];
    wire [7:0] ra = haddr[7:0];
    wire rd_rxd = take & ~hwrite & (ra == A_RXD);
    wire wr_now = wr_ff;
    wire w_txd = wr_now & (wa_ff == A_TXD);
    wire w_cp = wr_now & (wa_ff == A_CP);
    wire w_stat = wr_now & (wa_ff == A_STAT);
    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // Track a write into its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            wa_ff <= 8'h00;
        end else begin
            wr_ff <= take & hwrite;
            wa_ff <= ra;
        end
    end
    // Read mux; registered into hrdata
    logic [31:0] rmux;
    wire [6:0] stat = {irq_ff, d_act, fin_ff, unf_ff, ovf_ff, txs_ff, rxs_ff};
    always_comb begin
        case (ra)
            A_CTL: rmux = {24'h000000, ctl_ff};
            A_BAUD: rmux = {16'h0000, baud_ff};
            A_STAT: rmux = {25'h0000000, stat};
            A_TXD: rmux = txd_ff;
            A_RXD: rmux = rxd_ff;
            A_DCTL: rmux = {27'h0000000, dctl_ff};
            A_IDX: rmux = idx_ff;
            A_MOD: rmux = mod_ff;
            A_CNT: rmux = {16'h0000, cnt_ff};
            A_CP: rmux = cp_ff;
            A_IMSK: rmux = 32'(hmsk_ff) << HI_MSK_BIT;
            A_LMSK: rmux = 32'(lmsk_ff) << LO_MSK_BIT;
            default: rmux = ZERO32;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= ZERO32;
        end else if (take & ~hwrite) begin
            hrdata <= rmux;
        end
    end
    // ------------------------------
    // Pin synchronisers
    // ------------------------------
    logic [3:0] s1_ff, s2_ff;
    logic sclk_d_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Idle pin levels: clock low, select high
            s1_ff <= 4'h7;
            s2_ff <= 4'h7;
            sclk_d_ff <= 1'b0;
        end else begin
            s1_ff <= {serial_clock_i, select_input, mosi_i, miso_i};
            s2_ff <= s1_ff;
            sclk_d_ff <= s2_ff[3];
        end
    end
    wire sel_act = ~s2_ff[2] & en & ~master;
    // ------------------------------
    // Edge sources
    // ------------------------------
    ser_state_type sst_ff;
    logic [15:0] half_ff;      // Master half-period count
    logic [6:0] edges_ff;      // Master edges issued
    logic mclk_ff;             // Master clock level
    logic [5:0] bits_ff;       // Bits sampled
    wire half_up = (half_ff == 16'h0000);
    wire m_tog = master & (sst_ff == SER_SHIFT) & half_up;
    wire s_chg = ~master & (sst_ff == SER_SHIFT) & (s2_ff[3] != sclk_d_ff);
    wire lead = m_tog ? (mclk_ff == cpol) : s_chg & (s2_ff[3] != cpol);
    wire trail = m_tog ? (mclk_ff != cpol) : s_chg & (s2_ff[3] == cpol);
    wire samp = cpha ? trail : lead;
    wire shft = (cpha ? lead : trail) & (bits_ff != 6'h00);
    wire last = samp & (bits_ff == 6'(W - 1));
    wire in_bit = master ? s2_ff[0] : s2_ff[1];
    // ------------------------------
    // Transfer start and word source
    // ------------------------------
    wire tx_ok = dfull_ff;
    wire rx_ok = ~dfull_ff;
    logic m_go;
    always_comb begin
        if (d_act) begin
            m_go = d_rx ? rx_ok : tx_ok;          // Stall on DMA
        end else if (initiation_mode == TIM_RX) begin
            m_go = rd_rxd;
        end else if (initiation_mode == TIM_TX) begin
            m_go = w_txd;
        end else begin
            m_go = 1'b0;
        end
    end
    wire idle = (sst_ff == SER_IDLE);
    wire s_start = idle & sel_act;
    wire start = idle & (master ? en & m_go : s_start);
    logic [W-1:0] src;
    always_comb begin
        if (tx_dma) begin
            // Starved: zeros or last word repeated
            src = dfull_ff ? dbuf_ff[W-1:0] : (zfill ? '0 : last_tx_ff);
        end else if (rx_dma) begin
            src = zfill ? '0 : txd_ff[W-1:0];
        end else if (w_txd) begin
            // Word written this cycle goes out at once
            src = hwdata[W-1:0];
        end else begin
            src = txs_ff ? txd_ff[W-1:0] : (zfill ? '0 : last_tx_ff);
        end
    end
    wire src_dma = start & tx_dma & dfull_ff;
    wire src_core = start & ~d_act & (txs_ff | w_txd);
    // ------------------------------
    // Serial engine
    // ------------------------------
    logic [W-1:0] tsh_ff, rsh_ff;
    logic [2:0] lat_ff;
    logic pend_ff;
    wire h_reload = half_up | (sst_ff == SER_IDLE);
    // One word per pass; master timing from the divisor
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sst_ff <= SER_IDLE;
            half_ff <= 16'h0000;
            edges_ff <= 7'h00;
            mclk_ff <= 1'b0;
            bits_ff <= 6'h00;
            tsh_ff <= '0;
            rsh_ff <= '0;
            last_tx_ff <= '0;
        end else begin
            half_ff <= h_reload ? baud_ff - 16'h0001 : half_ff - 16'h0001;
            if (idle) begin
                mclk_ff <= cpol;
            end else if (m_tog) begin
                mclk_ff <= ~mclk_ff;
            end
            if (samp) begin
                rsh_ff <= {rsh_ff[W-2:0], in_bit};
                bits_ff <= bits_ff + 6'h01;
            end
            if (shft) begin
                tsh_ff <= {tsh_ff[W-2:0], 1'b0};
            end
            case (sst_ff)
                SER_IDLE: begin
                    edges_ff <= 7'h00;
                    bits_ff <= 6'h00;
                    if (start) begin
                        tsh_ff <= src;
                        last_tx_ff <= src;
                        sst_ff <= master ? SER_LEAD : SER_SHIFT;
                    end
                end
                SER_LEAD: begin
                    if (half_up) begin
                        sst_ff <= SER_SHIFT;
                    end
                end
                SER_SHIFT: begin
                    if (m_tog) begin
                        edges_ff <= edges_ff + 7'h01;
                        if (edges_ff == 7'(2 * W - 1)) begin
                            sst_ff <= SER_TAIL;
                        end
                    end else if (~master & ~sel_act) begin
                        sst_ff <= SER_IDLE;       // Deselect aborts
                    end else if (~master & last) begin
                        sst_ff <= cpha ? SER_IDLE : SER_TAIL;
                    end
                end
                SER_TAIL: begin
                    // Master waits half period; slave waits deselect
                    if (master ? half_up : ~sel_act) begin
                        sst_ff <= SER_IDLE;
                    end
                end
                default: sst_ff <= SER_IDLE;
            endcase
        end
    end
    // Receive-full latency after the last sampling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_ff <= 1'b0;
            lat_ff <= 3'h0;
        end else if (last) begin
            pend_ff <= 1'b1;
            lat_ff <= RXS_LAT - 3'h1;
        end else if (pend_ff) begin
            lat_ff <= lat_ff - 3'h1;
            pend_ff <= (lat_ff != 3'h0);
        end
    end
    wire commit = pend_ff & (lat_ff == 3'h0);
    wire m_fin = master & (sst_ff == SER_TAIL) & half_up;
    // ------------------------------
    // Pin drive
    // ------------------------------
    assign serial_clock_o = master ? mclk_ff : cpol;
    assign serial_clock_oe = en & master;
    assign select_out_n = ~(master & ~idle);
    assign mosi_o = tsh_ff[W-1];
    assign mosi_oe = en & master;
    assign miso_o = tsh_ff[W-1];
    assign miso_oe = sel_act;
    // ------------------------------
    // DMA engine
    // ------------------------------
    logic [1:0] dix_ff;        // Descriptor word index
    wire dxfer = dma_req.valid & dma_ready;
    wire d_need = (dst_ff == DMA_RUN) & (cnt_ff != 16'h0000)
                & (d_rx ? dfull_ff : ~dfull_ff);
    wire d_zero = (dst_ff == DMA_RUN) & (cnt_ff == 16'h0000)
                & (d_rx ? ~dfull_ff : 1'b1);
    wire chain_go = w_cp & ~d_act & en & d_en & dctl_ff[D_CH]
                  & (cnt_ff != 16'h0000);
    wire single_go = wr_now & (wa_ff == A_DCTL) & ~d_act & en
                   & hwdata[D_EN] & ~hwdata[D_CH] & (cnt_ff != 16'h0000);
    wire rx_in = commit & rx_dma;
    wire rx_drop = rx_in & dfull_ff & ~owr;
    wire d_done = (dst_ff == DMA_END);
    assign dma_req.valid = d_need | (dst_ff == DMA_DESC);
    assign dma_req.write = (dst_ff == DMA_RUN) & d_rx;
    assign dma_req.addr = (dst_ff == DMA_DESC) ? cp_ff + {28'h0, dix_ff, 2'h0} : idx_ff;
    assign dma_req.wdata = dbuf_ff;
    // Word moves, count, chaining
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dst_ff <= DMA_IDLE;
            dix_ff <= 2'h0;
            dfull_ff <= 1'b0;
            dbuf_ff <= ZERO32;
        end else begin
            if (rx_in & ~rx_drop) begin
                dbuf_ff <= 32'(rsh_ff);
                dfull_ff <= 1'b1;
            end else if (src_dma) begin
                dfull_ff <= 1'b0;
            end else if (dxfer & (dst_ff == DMA_RUN)) begin
                dbuf_ff <= dma_rdata;
                dfull_ff <= ~d_rx;
            end
            case (dst_ff)
                DMA_IDLE: begin
                    if (chain_go | single_go) begin
                        dst_ff <= DMA_RUN;
                    end
                end
                DMA_RUN: begin
                    if (d_zero) begin
                        dst_ff <= DMA_END;
                    end
                end
                DMA_END: begin
                    dix_ff <= 2'h0;
                    dst_ff <= (dctl_ff[D_CH] & cp_ff != ZERO32) ? DMA_DESC : DMA_IDLE;
                end
                DMA_DESC: begin
                    if (dxfer) begin
                        dix_ff <= dix_ff + 2'h1;
                        if (dix_ff == 2'h3) begin
                            dst_ff <= DMA_RUN;
                        end
                    end
                end
                default: dst_ff <= DMA_IDLE;
            endcase
        end
    end
    // ------------------------------
    // Software registers
    // ------------------------------
    wire ld_desc = dxfer & (dst_ff == DMA_DESC);
    wire ld_word = dxfer & (dst_ff == DMA_RUN);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_ff <= 8'h00;
            baud_ff <= BAUD_RST;
            dctl_ff <= 5'h00;
            txd_ff <= ZERO32;
            idx_ff <= ZERO32;
            mod_ff <= ZERO32;
            cnt_ff <= 16'h0000;
            cp_ff <= ZERO32;
            hmsk_ff <= 1'b0;
            lmsk_ff <= 1'b0;
        end else begin
            if (wr_now) begin
                case (wa_ff)
                    A_CTL: ctl_ff <= hwdata[7:0];
                    A_BAUD: baud_ff <= hwdata[15:0];
                    A_DCTL: dctl_ff <= hwdata[4:0];
                    A_TXD: txd_ff <= hwdata;
                    A_IDX: idx_ff <= hwdata;
                    A_MOD: mod_ff <= hwdata;
                    A_CNT: cnt_ff <= hwdata[15:0];
                    A_CP: cp_ff <= d_act ? cp_ff : hwdata;
                    A_IMSK: hmsk_ff <= hwdata[HI_MSK_BIT];
                    A_LMSK: lmsk_ff <= hwdata[LO_MSK_BIT];
                    default: ;
                endcase
            end
            if (ld_word) begin
                idx_ff <= idx_ff + mod_ff;
                cnt_ff <= cnt_ff - 16'h0001;
            end
            if (ld_desc) begin
                case (dix_ff)
                    2'h0: idx_ff <= dma_rdata;
                    2'h1: mod_ff <= dma_rdata;
                    2'h2: cnt_ff <= dma_rdata[15:0];
                    default: cp_ff <= dma_rdata;
                endcase
            end
        end
    end
    // ------------------------------
    // Status flags (set beats clear, except transmit-full: a send clears it)
    // ------------------------------
    wire rx_core = commit & ~rx_dma;
    wire rx_upd = rx_core & (~rxs_ff | owr);
    wire ovf_set = (rx_core & rxs_ff & ~owr) | rx_drop;
    wire unf_set = start & tx_dma & ~dfull_ff;
    wire fin_set = master ? m_fin : commit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxd_ff <= ZERO32;
            rxs_ff <= 1'b0;
            txs_ff <= 1'b0;
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
            fin_ff <= 1'b0;
        end else begin
            if (rx_upd) begin
                rxd_ff <= 32'(rsh_ff);
            end
            rxs_ff <= rx_upd | (rxs_ff & ~rd_rxd);
            txs_ff <= (w_txd | txs_ff) & ~src_core;
            ovf_ff <= ovf_set | (ovf_ff & ~(w_stat & hwdata[S_OVF]));
            unf_ff <= unf_set | (unf_ff & ~(w_stat & hwdata[S_UNF]));
            fin_ff <= fin_set | (fin_ff & ~start);
        end
    end
    // ------------------------------
    // Interrupt latch
    // ------------------------------
    // Core causes only without DMA; the idle direction stays quiet
    // The latch register alone gives the one-cycle lag after receive-full
    wire core_src = ~d_act & ((initiation_mode == TIM_RX) ? rxs_ff : ~txs_ff);
    wire err_src = (rx_dma & ovf_set) | (tx_dma & unf_set);
    wire dma_src = (d_done & dctl_ff[D_IE]) | (err_src & dctl_ff[D_EE]);
    wire irq_set = (core_src & en & (initiation_mode != 2'h2)) | dma_src;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_set | (irq_ff & ~(w_stat & hwdata[S_IRQ]));
        end
    end
    assign high_priority_serial_irq = PRIMARY & irq_ff & hmsk_ff;
    assign low_priority_serial_irq = ~PRIMARY & irq_ff & lmsk_ff;
endmodule : spi_dma_port

// ### spi_dma_port_sva.sv
module spi_dma_chk
    import spi_dma_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer
    input wire logic hresp,
    input wire logic hreadyout,
    // Serial pins
    input wire logic serial_clock_o,
    input wire logic serial_clock_oe,
    input wire logic select_input,
    input wire logic select_out_n,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    // Memory side and irq
    input wire mem_req_type dma_req,
    input wire logic dma_ready,
    input wire logic low_priority_serial_irq
);
    // ----------------------------------------
    // Properties, one clock domain
    // ----------------------------------------
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (!hresp && hreadyout)
        else $error("bus answer not okay");
    a_oe_apart: assert property (!(mosi_oe && miso_oe))
        else $error("both data drivers on");
    a_clk_owner: assert property (serial_clock_oe == mosi_oe)
        else $error("clock driver without master");
    a_sel_master: assert property (!select_out_n |-> mosi_oe)
        else $error("select out low outside master");
    a_lead_half: assert property ($fell(select_out_n) |=> $stable(serial_clock_o) [*2])
        else $error("clock moved before half period");
    a_desel_quiet: assert property (select_input [*4] |-> !miso_oe)
        else $error("slave drives while unselected");
    a_mem_hold: assert property (dma_req.valid && !dma_ready |=> $stable(dma_req))
        else $error("memory request dropped before ready");
    a_low_irq: assert property (!low_priority_serial_irq)
        else $error("primary port raised low irq");
    // Main scenarios reached
    c_master: cover property ($fell(select_out_n));
    c_slave: cover property (miso_oe);
    c_mem: cover property (dma_req.valid && dma_ready);
endmodule : spi_dma_chk

bind spi_dma_port spi_dma_chk spi_dma_chk_i (.hclk, .hresetn, .hresp, .hreadyout,
    .serial_clock_o, .serial_clock_oe, .select_input, .select_out_n, .mosi_oe,
    .miso_oe, .dma_req, .dma_ready, .low_priority_serial_irq);

// ### spi_far_end.sv
module spi_far_end (
    // Noise clock
    input wire logic hclk,
    // From the block
    input wire logic select_out_n,
    input wire logic mosi_o,
    input wire logic miso_o,
    input wire logic serial_clock_o,
    // To the block
    output logic serial_clock_i,
    output logic select_input,
    output logic mosi_i,
    output logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic mo = 1'b0; // Last data bit
    logic tog = 1'b0; // Idle noise
    logic [31:0] got_s = 32'h0; // Word from the slave
    logic [31:0] got_m = 32'h0; // Word from the master
    initial begin
        serial_clock_i = 1'b0;
        select_input = 1'b1;
    end
    always @(posedge hclk) tog <= ~tog;
    // Released lines keep no stale level
    assign mosi_i = select_input ? ~mo : mo;
    assign miso_i = select_out_n ? tog : mosi_o; // Echo as slave
    // Leading edge sampling
    always @(posedge serial_clock_o) if (!select_out_n) got_m <= {got_m[30:0], mosi_o};
    // ----------------------------------------
    // Master frame: phase 0, clock stands between
    // ----------------------------------------
    task automatic send(input logic [31:0] w);
        #5 select_input = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mo = w[i];
            #80 serial_clock_i = 1'b1;
            got_s = {got_s[30:0], miso_o};
            #80 serial_clock_i = 1'b0;
        end
        #80 select_input = 1'b1;
        #240;
    endtask : send
endmodule : spi_far_end

// ### test_spi_dma_port.sv
module test_spi_dma_port
    import spi_dma_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic dma_ready = 1'b0;
    logic [31:0] hrdata, q, m_addr, m_data;
    logic hreadyout, hresp, serial_clock_i, serial_clock_o, serial_clock_oe;
    logic select_input, select_out_n, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
    logic high_priority_serial_irq, low_priority_serial_irq;
    mem_req_type dma_req;
    int error_cnt = 0;
    int samples_checked = 0;
    spi_dma_port spi_dma_port_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .serial_clock_i, .serial_clock_o, .serial_clock_oe, .select_input, .select_out_n,
        .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .dma_req, .dma_ready,
        .dma_rdata(32'h0), .high_priority_serial_irq, .low_priority_serial_irq);
    spi_far_end spi_far_end_i (.hclk, .select_out_n, .mosi_o, .miso_o, .serial_clock_o,
        .serial_clock_i, .select_input, .mosi_i, .miso_i);
    initial begin
        forever #10 hclk = ~hclk;
    end
    // Memory stalls every other cycle
    always @(posedge hclk) dma_ready <= ~dma_ready;
    always @(posedge hclk) if (dma_req.valid && dma_ready && dma_req.write) begin
        m_addr <= dma_req.addr;
        m_data <= dma_req.wdata;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic give_up;
        error_cnt++;
        $display("BAD %0t wait ran out", $time);
        finish_test;
    endtask : give_up
    // Waits for hready, bounded
    task automatic hwait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) give_up;
    endtask : hwait
    // One single word transfer; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hwait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hwait;
        q = hrdata;
    endtask : bus
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do begin
            bus(1'b0, A_STAT, 32'h0);
            n++;
        end while (q[b] !== v && n < 800);
        if (n >= 800) give_up;
    endtask : poll
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, A_BAUD, 32'h0);
        chk(q, {16'h0, BAUD_RST});
        bus(1'b0, 8'h3C, 32'h0);
        chk(q, 32'h0);
        // Master started by transmit write
        bus(1'b1, A_CTL, 32'h13);
        bus(1'b1, A_TXD, 32'hC3A5_0F96);
        poll(S_FIN, 1'b1);
        chk(spi_far_end_i.got_m, 32'hC3A5_0F96);
        poll(S_RXS, 1'b1);
        bus(1'b0, A_RXD, 32'h0);
        chk(q, 32'hC3A5_0F96);
        // Slave core transfer, receive interrupt unmasked
        bus(1'b1, A_CTL, 32'h01);
        bus(1'b1, A_STAT, 32'h40);
        bus(1'b1, A_IMSK, 32'h1000);
        bus(1'b1, A_TXD, 32'h9669_3CC3);
        chk({31'h0, high_priority_serial_irq}, 32'h0);
        spi_far_end_i.send(32'h1234_ABCD);
        poll(S_RXS, 1'b1);
        chk({31'h0, high_priority_serial_irq}, 32'h1);
        chk(spi_far_end_i.got_s, 32'h9669_3CC3);
        bus(1'b0, A_RXD, 32'h0);
        chk(q, 32'h1234_ABCD);
        bus(1'b0, A_STAT, 32'h0);
        chk({31'h0, q[S_RXS]}, 32'h0);
        bus(1'b1, A_STAT, 32'h40);
        @(negedge hclk);
        chk({31'h0, high_priority_serial_irq}, 32'h0);
        // Slave receive DMA of one word
        bus(1'b1, A_CTL, 32'h21);
        bus(1'b1, A_IDX, 32'h100);
        bus(1'b1, A_CNT, 32'h1);
        bus(1'b1, A_DCTL, 32'h3);
        spi_far_end_i.send(32'h5EED_0042);
        poll(S_DACT, 1'b0);
        chk(m_addr, 32'h100);
        chk(m_data, 32'h5EED_0042);
        bus(1'b0, A_CNT, 32'h0);
        chk(q, 32'h0);
        finish_test;
    end
endmodule : test_spi_dma_port
